// ### tape_cmd_params.svh
// constants for the command-buffer ownership block
`ifndef TAPE_CMD_PARAMS_SVH
`define TAPE_CMD_PARAMS_SVH

`define TAPE_ADDR_W 8
`define TAPE_DATA_W 32
`define TAPE_OFF_PTR 8'h00
`define TAPE_OFF_STATUS 8'h04

`define TAPE_ST_CMD_DEV 0
`define TAPE_ST_REPLY_DEV 1
`define TAPE_ST_IE 2
`define TAPE_ST_NOTICE_EN 3
`define TAPE_ST_NOTICE_PEND 4
`define TAPE_ST_REJECT 5
`define TAPE_ST_BUSY 6
`define TAPE_ST_READY 7

`define TAPE_WR_INIT 0
`define TAPE_WR_CLR_REJECT 5

`define TAPE_PTR_RST 32'h00000000
`define TAPE_REPLY_ADDR_RST 32'h00000000
`define TAPE_STATUS_RST 32'h00000000

`define TAPE_RESP_OKAY 2'h0
`define TAPE_RESP_SLVERR 2'h2

`endif

// ### tape_cmd_pkg.sv
// types shared by the ownership block
package tape_cmd_pkg;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_REPLY = 2'b10
  } state_t;
endpackage : tape_cmd_pkg

// ### tape_axil_slave.sv
// axi4-lite slave front end for the two-word register window
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module tape_axil_slave
  import tape_cmd_pkg::*;
#(
  parameter int ADDR_W = `TAPE_ADDR_W,
  parameter int DATA_W = `TAPE_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [DATA_W/8-1:0] wr_strb,
  input wire logic wr_err,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [DATA_W/8-1:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;

  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire have_aw = aw_held_reg || aw_hs;
  wire have_w = w_held_reg || w_hs;

  // address and data may arrive in either order; hold whichever comes first
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_en = have_aw && have_w && !bvalid_reg;
  assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      aw_held_reg <= have_aw && !wr_en;
      w_held_reg <= have_w && !wr_en;
      if (aw_hs) aw_addr_reg <= s_axi_awaddr;
      if (w_hs) w_data_reg <= s_axi_wdata;
      if (w_hs) w_strb_reg <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `TAPE_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err ? `TAPE_RESP_SLVERR : `TAPE_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `TAPE_RESP_OKAY;
      rdata_reg <= '0;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_err ? `TAPE_RESP_SLVERR : `TAPE_RESP_OKAY;
      rdata_reg <= rd_err ? '0 : rd_data;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule : tape_axil_slave

// ### tape_cmd_buffer_ownership.sv
// command and reply area ownership handshake with two-word register window
// Operation
// - only two registers; packets live in memory
// - reply area written only while device owns
// - configuration command supplies reply area address
// - each area has exactly one owner
// - only the current owner hands an area over
// - initialize aborts and returns both areas
// - both areas pass together, both return together (the code lends the reply area at command finish; release leaves it lent)
// - pointer write clears the ready flag
// - reply with handoff bit returns command area
// - ready flag set only after reply deposited
// - no handoff: ready, optional interrupt, no message
// - reply area returned by write plus ready
// - notices only while idle with ready set (the code also sends a queued notice in place of a lent command's reply)
// - notice: clear ready, write, set ready, interrupt
// - notice interrupt follows lending command enable
// - notices only if configuration enabled them
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module tape_cmd_buffer_ownership
  import tape_cmd_pkg::*;
#(
  parameter int ADDR_W = `TAPE_ADDR_W,
  parameter int DATA_W = `TAPE_DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic init_req,
  output logic cmd_start,
  output logic [DATA_W-1:0] cmd_pointer,
  input wire logic exec_done,
  input wire logic exec_handoff,
  input wire logic exec_ie,
  input wire logic exec_decoded,
  input wire logic exec_config,
  input wire logic exec_release,
  input wire logic [DATA_W-1:0] cfg_reply_addr,
  input wire logic cfg_notice_en,
  input wire logic exception_notice,
  output logic reply_wr_valid,
  input wire logic reply_wr_done,
  output logic [DATA_W-1:0] reply_addr,
  output logic reply_handoff,
  output logic reply_is_notice,
  output logic completion_interrupt
);
  state_t state_reg;
  state_t state_next;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W/8-1:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_err;
  logic rd_err;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] ptr_reg;
  logic [DATA_W-1:0] ptr_next;
  logic [DATA_W-1:0] reply_addr_reg;
  logic subsystem_ready_flag;
  logic ready_next;
  logic cmd_dev_reg;
  logic cmd_dev_next;
  logic reply_dev_reg;
  logic reply_dev_next;
  logic completion_interrupt_enable;
  logic lend_ie_reg;
  logic exception_notice_enable;
  logic pend_reg;
  logic pend_next;
  logic reject_reg;
  logic reject_next;
  logic reply_ack_reg;
  logic reply_notice_reg;
  logic cmd_start_reg;
  logic irq_reg;
  logic irq_next;

  tape_axil_slave #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_bus (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // decode: the whole host view is these two words
  wire wr_ptr_sel = wr_addr == `TAPE_OFF_PTR;
  wire wr_stat_sel = wr_addr == `TAPE_OFF_STATUS;
  assign wr_err = !(wr_ptr_sel || wr_stat_sel);
  wire rd_ptr_sel = rd_addr == `TAPE_OFF_PTR;
  wire rd_stat_sel = rd_addr == `TAPE_OFF_STATUS;
  assign rd_err = !(rd_ptr_sel || rd_stat_sel);
  wire ptr_hit = wr_en && wr_ptr_sel;
  wire stat_hit = wr_en && wr_stat_sel && wr_strb[0];
  wire sw_init = stat_hit && wr_data[`TAPE_WR_INIT];
  wire clr_reject = stat_hit && wr_data[`TAPE_WR_CLR_REJECT];
  wire init_any = init_req || sw_init;

  // pointer write only starts a command while the device is ready
  wire cmd_take = ptr_hit && subsystem_ready_flag && !init_any;
  wire cmd_refuse = ptr_hit && !subsystem_ready_flag && !init_any;
  wire exec_fin = state_reg == S_EXEC && exec_done && !init_any;
  wire exec_quiet = exec_fin && (!exec_handoff || exec_release);
  // a queued notice replaces a lent command, except configuration or release
  wire exec_notice = exec_fin && exec_handoff && !exec_release &&
                     !exec_config && pend_reg && exception_notice_enable;
  wire idle_notice = state_reg == S_IDLE && subsystem_ready_flag &&
                     reply_dev_reg && exception_notice_enable && pend_reg &&
                     !ptr_hit && !init_any;
  wire notice_go = idle_notice || exec_notice;
  wire reply_fin = state_reg == S_REPLY && reply_wr_done && !init_any;

  always_comb begin
    status_word = `TAPE_STATUS_RST;
    status_word[`TAPE_ST_CMD_DEV] = cmd_dev_reg;
    status_word[`TAPE_ST_REPLY_DEV] = reply_dev_reg;
    status_word[`TAPE_ST_IE] = completion_interrupt_enable;
    status_word[`TAPE_ST_NOTICE_EN] = exception_notice_enable;
    status_word[`TAPE_ST_NOTICE_PEND] = pend_reg;
    status_word[`TAPE_ST_REJECT] = reject_reg;
    status_word[`TAPE_ST_BUSY] = state_reg != S_IDLE;
    status_word[`TAPE_ST_READY] = subsystem_ready_flag;
  end

  assign rd_data = rd_ptr_sel ? ptr_reg :
                   rd_stat_sel ? status_word : '0;

  genvar b;
  generate
    for (b = 0; b < DATA_W/8; b = b + 1) begin : g_ptr_byte
      assign ptr_next[b*8 +: 8] = (cmd_take && wr_strb[b]) ?
                                  wr_data[b*8 +: 8] : ptr_reg[b*8 +: 8];
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (cmd_take) state_next = S_EXEC;
        else if (idle_notice) state_next = S_REPLY;
      end
      S_EXEC: begin
        if (exec_quiet) state_next = S_IDLE;
        else if (exec_fin) state_next = S_REPLY;
      end
      S_REPLY: begin
        if (reply_fin) state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
    if (init_any) state_next = S_IDLE;
  end

  // ready drops on a taken pointer or a notice; rises after the deposit or on a quiet finish (exec_quiet)
  assign ready_next = init_any ? 1'b1 :
                      (cmd_take || idle_notice) ? 1'b0 :
                      (reply_fin || exec_quiet) ? 1'b1 :
                      subsystem_ready_flag;
  // command area goes out on a taken pointer, reply area at a lending finish; exec_quiet returns only the command area
  assign cmd_dev_next = init_any ? 1'b0 :
                        cmd_take ? 1'b1 :
                        (reply_fin || exec_quiet) ? 1'b0 :
                        cmd_dev_reg;
  assign reply_dev_next = init_any ? 1'b0 :
                          (exec_fin && exec_handoff) ? 1'b1 :
                          reply_fin ? 1'b0 :
                          reply_dev_reg;
  // a notice arriving as the pending one is taken stays queued
  assign pend_next = exception_notice ||
                     (pend_reg && !notice_go && !init_any);
  assign reject_next = cmd_refuse || (reject_reg && !clr_reject);
  assign irq_next = !init_any &&
    ((reply_fin && (reply_notice_reg ? lend_ie_reg :
                    completion_interrupt_enable)) ||
     (exec_quiet && exec_ie && (!exec_release || exception_notice_enable)));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      subsystem_ready_flag <= 1'b1;
      cmd_dev_reg <= 1'b0;
      reply_dev_reg <= 1'b0;
      pend_reg <= 1'b0;
      reject_reg <= 1'b0;
      irq_reg <= 1'b0;
      cmd_start_reg <= 1'b0;
      ptr_reg <= `TAPE_PTR_RST;
    end else begin
      state_reg <= state_next;
      subsystem_ready_flag <= ready_next;
      cmd_dev_reg <= cmd_dev_next;
      reply_dev_reg <= reply_dev_next;
      pend_reg <= pend_next;
      reject_reg <= reject_next;
      irq_reg <= irq_next;
      cmd_start_reg <= cmd_take;
      ptr_reg <= ptr_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_addr_reg <= `TAPE_REPLY_ADDR_RST;
      exception_notice_enable <= 1'b0;
      completion_interrupt_enable <= 1'b0;
      lend_ie_reg <= 1'b0;
    end else if (exec_fin) begin
      completion_interrupt_enable <= exec_ie;
      if (exec_handoff) lend_ie_reg <= exec_ie;
      if (exec_config) reply_addr_reg <= cfg_reply_addr;
      if (exec_config) exception_notice_enable <= cfg_notice_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_ack_reg <= 1'b0;
      reply_notice_reg <= 1'b0;
    end else if (notice_go) begin
      reply_ack_reg <= 1'b0;
      reply_notice_reg <= 1'b1;
    end else if (exec_fin) begin
      reply_ack_reg <= exec_decoded;
      reply_notice_reg <= 1'b0;
    end
  end

  // the reply port only opens while the device holds the reply area
  assign reply_wr_valid = state_reg == S_REPLY && reply_dev_reg;
  assign reply_addr = reply_addr_reg;
  assign reply_handoff = reply_ack_reg;
  assign reply_is_notice = reply_notice_reg;
  assign cmd_start = cmd_start_reg;
  assign cmd_pointer = ptr_reg;
  assign completion_interrupt = irq_reg;

  sequence notice_open_s;
    state_reg == S_IDLE && subsystem_ready_flag ##1
    state_reg == S_REPLY && !subsystem_ready_flag;
  endsequence

  sequence reply_close_s;
    reply_wr_valid && reply_wr_done ##1 subsystem_ready_flag;
  endsequence

  ptr_clear_ready_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cmd_take |=> !subsystem_ready_flag && cmd_start && cmd_dev_reg)
    else $error("pointer write did not clear ready");

  reply_owned_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reply_wr_valid |-> reply_dev_reg && !subsystem_ready_flag)
    else $error("reply written without ownership");

  init_return_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    init_any |=> !cmd_dev_reg && !reply_dev_reg && state_reg == S_IDLE)
    else $error("initialize left an area with the device");

  ready_after_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reply_fin |=> subsystem_ready_flag && !reply_dev_reg && !cmd_dev_reg)
    else $error("ready not raised after reply");

  quiet_cmd_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    exec_fin && !exec_handoff |=> subsystem_ready_flag && !reply_wr_valid
      && completion_interrupt ==
      $past(exec_ie && (!exec_release || exception_notice_enable)))
    else $error("unlent command misbehaved");

  notice_gate_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    notice_open_s |-> exception_notice_enable && reply_is_notice
      && !reply_handoff)
    else $error("notice without enable");

  notice_steps_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reply_is_notice && reply_fin |-> reply_close_s)
    else $error("notice sequence out of order");

  notice_irq_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    reply_is_notice && reply_fin |=> completion_interrupt == lend_ie_reg)
    else $error("notice interrupt ignored lending enable");

  cfg_addr_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    exec_fin && exec_config |=> reply_addr == $past(cfg_reply_addr))
    else $error("reply address not taken from configuration");

  cmd_owner_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    $fell(cmd_dev_reg) |-> $past(reply_fin || exec_quiet || init_any))
    else $error("command area returned without owner action");

  notice_idle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    idle_notice |-> subsystem_ready_flag && !cmd_dev_reg)
    else $error("notice raised while active");
endmodule : tape_cmd_buffer_ownership

// ### exec_partner_model.sv
// partner model: command engine and reply writer with set latencies
`timescale 1ns/1ps
module exec_partner_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_start,
  input wire logic reply_wr_valid,
  input wire logic [7:0] exec_lat,
  input wire logic [7:0] reply_lat,
  output logic exec_done,
  output logic reply_wr_done
);
  logic [7:0] exec_cnt;
  logic [7:0] reply_cnt;
  // no abort input: a stale done may arrive after an initialize
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_cnt <= 8'h00;
      reply_cnt <= 8'h00;
      exec_done <= 1'h0;
      reply_wr_done <= 1'h0;
    end else begin
      exec_done <= 1'h0;
      reply_wr_done <= 1'h0;
      if (cmd_start) begin
        exec_cnt <= exec_lat;
      end else if (exec_cnt != 8'h00) begin
        exec_cnt <= exec_cnt - 8'h01;
        exec_done <= (exec_cnt == 8'h01);
      end
      // one done per reply, only while one is asked for
      if (!reply_wr_valid) begin
        reply_cnt <= reply_lat;
      end else if (reply_cnt != 8'h00) begin
        reply_cnt <= reply_cnt - 8'h01;
        reply_wr_done <= (reply_cnt == 8'h01);
      end
    end
  end
endmodule : exec_partner_model

// ### tb_top.sv
// testbench for the command and reply area ownership block
`timescale 1ns/1ps
`include "tape_cmd_params.svh"
module tb_top;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, cmd_pointer, reply_addr, rep_addr, rd;
  logic init_req = 1'h0, exception_notice = 1'h0;
  logic exec_handoff = 1'h0, exec_ie = 1'h0, exec_decoded = 1'h0;
  logic exec_config = 1'h0, exec_release = 1'h0, cfg_notice_en = 1'h0;
  logic [31:0] cfg_reply_addr = 32'h0;
  logic cmd_start, exec_done, reply_wr_done, reply_wr_valid;
  logic reply_handoff, reply_is_notice, completion_interrupt;
  logic [7:0] exec_lat = 8'h1E, reply_lat = 8'h03;
  logic rep_prev = 1'h0, rep_hand, rep_note;
  int err_count = 0, comparisons = 0;
  int irq_cnt = 0, start_cnt = 0, rep_cnt = 0;

  always #12.5 sys_clk = ~sys_clk;

  tape_cmd_buffer_ownership dut_u (
    .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .init_req, .cmd_start, .cmd_pointer,
    .exec_done, .exec_handoff, .exec_ie, .exec_decoded, .exec_config,
    .exec_release, .cfg_reply_addr, .cfg_notice_en, .exception_notice,
    .reply_wr_valid, .reply_wr_done, .reply_addr, .reply_handoff,
    .reply_is_notice, .completion_interrupt
  );

  exec_partner_model partner_u (
    .sys_clk, .rst_n, .cmd_start, .reply_wr_valid, .exec_lat, .reply_lat,
    .exec_done, .reply_wr_done
  );

  // event counts and the fields of the latest reply
  always @(posedge sys_clk) begin
    if (completion_interrupt === 1'h1) irq_cnt++;
    if (cmd_start === 1'h1) start_cnt++;
    if (reply_wr_valid === 1'h1 && !rep_prev) rep_cnt++;
    if (reply_wr_valid === 1'h1) begin
      rep_addr = reply_addr;
      rep_hand = reply_handoff;
      rep_note = reply_is_notice;
    end
    rep_prev = (reply_wr_valid === 1'h1);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // address and data may be taken at different edges
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready === 1'h1) begin
        ad = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready === 1'h1) begin
        wd = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge sys_clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    while (s_axi_rvalid !== 1'h1) @(posedge sys_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : axi_rd

  task automatic chk_rsp(input logic [1:0] want);
    check({30'h0, rsp}, {30'h0, want});
  endtask : chk_rsp

  task automatic st_chk(input logic [31:0] m, input logic [31:0] want);
    axi_rd(`TAPE_OFF_STATUS, rd, rsp);
    check(rd & m, want);
  endtask : st_chk

  // fields: handoff, ie, decoded, config, release
  task automatic cmd(input logic [31:0] p, input logic [4:0] f);
    {exec_handoff, exec_ie, exec_decoded, exec_config, exec_release} <= f;
    axi_wr(`TAPE_OFF_PTR, p, 4'hF, rsp);
  endtask : cmd

  task automatic wait_ready;
    do axi_rd(`TAPE_OFF_STATUS, rd, rsp); while (rd[7] !== 1'h1);
  endtask : wait_ready

  task automatic notice_pulse;
    @(posedge sys_clk);
    exception_notice <= 1'h1;
    @(posedge sys_clk);
    exception_notice <= 1'h0;
  endtask : notice_pulse

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    st_chk(32'hFFFFFFFF, 32'h00000080);
    axi_rd(8'h08, rd, rsp);
    chk_rsp(`TAPE_RESP_SLVERR);
    check(rd, 32'h0);
    axi_wr(8'h08, 32'hFFFFFFFF, 4'hF, rsp);
    chk_rsp(`TAPE_RESP_SLVERR);
    // configuration command: reply address and notice enable
    cfg_reply_addr <= 32'h00002000;
    cfg_notice_en <= 1'h1;
    cmd(32'h00000100, 5'h16);
    chk_rsp(`TAPE_RESP_OKAY);
    st_chk(32'h000000C1, 32'h00000041);
    wait_ready;
    check(cmd_pointer, 32'h00000100);
    check(rep_addr, 32'h00002000);
    check({31'h0, rep_hand}, 32'h1);
    check(32'(irq_cnt), 32'h0);
    st_chk(32'hFFFFFFFF, 32'h00000088);
    // undecoded command, slow reply writer
    reply_lat <= 8'h1E;
    cmd(32'h00000200, 5'h18);
    wait (reply_wr_valid === 1'h1);
    st_chk(32'h00000080, 32'h0);
    wait_ready;
    check({31'h0, rep_hand}, 32'h0);
    check(32'(irq_cnt), 32'h1);
    st_chk(32'hFFFFFFFF, 32'h0000008C);
    // reply area kept by host; second pointer write while busy
    reply_lat <= 8'h03;
    cmd(32'h00000300, 5'h08);
    axi_wr(`TAPE_OFF_PTR, 32'h00000400, 4'hF, rsp);
    st_chk(32'h00000020, 32'h00000020);
    wait_ready;
    check(32'(start_cnt), 32'h3);
    check(cmd_pointer, 32'h00000300);
    check(32'(rep_cnt), 32'h2);
    check(32'(irq_cnt), 32'h2);
    axi_wr(`TAPE_OFF_STATUS, 32'h00000020, 4'h1, rsp);
    st_chk(32'h00000020, 32'h0);
    // lend the reply area, then an exception notice
    cmd(32'h00000500, 5'h1D);
    wait_ready;
    check(32'(rep_cnt), 32'h2);
    check(32'(irq_cnt), 32'h3);
    st_chk(32'h00000083, 32'h00000082);
    reply_lat <= 8'h1E;
    notice_pulse;
    wait (reply_wr_valid === 1'h1);
    st_chk(32'h00000080, 32'h0);
    wait_ready;
    check({30'h0, rep_note, rep_hand}, 32'h2);
    check(rep_addr, 32'h00002000);
    check(32'(irq_cnt), 32'h4);
    st_chk(32'h00000093, 32'h00000080);
    // notice while host holds the reply area stays queued
    notice_pulse;
    st_chk(32'h00000093, 32'h00000090);
    check(32'(rep_cnt), 32'h3);
    axi_wr(`TAPE_OFF_STATUS, 32'h00000001, 4'h1, rsp);
    st_chk(32'h000000F3, 32'h00000080);
    // initialize in mid-command; late done must be ignored
    cmd(32'h00000600, 5'h14);
    st_chk(32'h00000041, 32'h00000041);
    @(posedge sys_clk);
    init_req <= 1'h1;
    @(posedge sys_clk);
    init_req <= 1'h0;
    st_chk(32'h000000F3, 32'h00000080);
    repeat (40) @(posedge sys_clk);
    check(32'(rep_cnt), 32'h3);
    st_chk(32'h000000F3, 32'h00000080);
    // queued notice takes the place of a lent plain command
    notice_pulse;
    cmd(32'h00000700, 5'h18);
    wait_ready;
    check({30'h0, rep_note, rep_hand}, 32'h2);
    check(32'(rep_cnt), 32'h4);
    check(32'(irq_cnt), 32'h5);
    st_chk(32'h000000F3, 32'h00000080);
    conclude;
  end
endmodule : tb_top
